/* lpcfe_top.v */
// Contract
// - Mode high: parallel programming on, bus off
// - Mode low: bus interface enabled
// - Frame assertion starts a new cycle
// - Frame during a cycle aborts it
// - Four-bit lines carry requests in, responses out
// - Control unit runs on the bus clock
// - Primary reset resets every operation
// - Second reset acts like primary reset
`include "lpcfe_map.vh"
`timescale 1ns/1ns
`default_nettype none

module lpcfe_top #(
  parameter NIB_W = 4,
  parameter IDX_W = 5
) (
  // Bus clock and resets
  input wire mclk,
  input wire nrst,
  input wire init_n,
  // Interface strap
  input wire mode_pin,
  output reg parallel_programming_mode,
  output reg lpc_mode,
  // Bus pins
  input wire lframe_n,
  input wire [NIB_W-1:0] lad_i,
  output reg [NIB_W-1:0] lad_o,
  output reg lad_oe_n,
  // Request side towards the memory core
  output reg cyc_start,
  output reg [NIB_W-1:0] cyc_type,
  output reg cyc_active,
  output reg cyc_abort,
  output reg nib_valid,
  output reg [NIB_W-1:0] nib_data,
  output reg [IDX_W-1:0] nib_idx,
  input wire cyc_end,
  // Response side from the memory core
  input wire resp_valid,
  input wire [NIB_W-1:0] resp_data,
  input wire resp_last,
  output wire resp_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // Strap and second reset synchronisers

  wire mode_sync;
  wire init_sync_n;

  lpcfe_sync #(
    .WIDTH(2),
    .RST_VAL(2'h0)
  ) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .async_in({mode_pin, init_n}),
    .sync_out({mode_sync, init_sync_n})
  );

  // Second reset clears the same state the primary one does
  wire soft_rst = ~init_sync_n;

  ////////////////////////////////////////////////////////////////////////////
  // Mode capture

  reg [`LPCFE_STRAP_CNT_W-1:0] strap_cnt_r;
  reg strap_done_r;

  // Strap caught once after release and frozen; later pin changes are
  // ignored, so a misbehaving board cannot swap interfaces mid-operation.
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      strap_cnt_r <= {`LPCFE_STRAP_CNT_W{1'b0}};
      strap_done_r <= 1'b0;
      parallel_programming_mode <= 1'b0;
      lpc_mode <= 1'b0;
    end else if (soft_rst) begin
      strap_cnt_r <= {`LPCFE_STRAP_CNT_W{1'b0}};
      strap_done_r <= 1'b0;
      parallel_programming_mode <= 1'b0;
      lpc_mode <= 1'b0;
    end else if (!strap_done_r) begin
      if (strap_cnt_r == `LPCFE_STRAP_WAIT) begin
        strap_done_r <= 1'b1;
        parallel_programming_mode <= mode_sync;
        lpc_mode <= ~mode_sync;
      end else begin
        strap_cnt_r <= strap_cnt_r + 1'b1;
      end
    end
  end

  // Bus logic idles unless the held strap chose it
  wire lpc_run = lpc_mode & ~soft_rst;

  ////////////////////////////////////////////////////////////////////////////
  // Start code check

  function is_start;
    input [NIB_W-1:0] code;
    begin
      is_start = (code == `LPCFE_START_MEM) ||
                 (code == `LPCFE_START_FW_RD) ||
                 (code == `LPCFE_START_FW_WR);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Cycle state machine, clocked from the bus clock

  reg [`LPCFE_ST_W-1:0] state_r;
  reg [`LPCFE_ST_W-1:0] state_nxt;
  reg [NIB_W-1:0] code_r;

  wire in_frame = ~lframe_n;
  wire driving = (state_r == `LPCFE_ST_CYCLE) & resp_valid;

  // Core may only talk while a cycle stands and the frame is quiet
  assign resp_ready = lpc_run & (state_r == `LPCFE_ST_CYCLE) & lframe_n;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      `LPCFE_ST_IDLE: begin
        if (in_frame) begin
          state_nxt = `LPCFE_ST_FRAME;
        end
      end
      `LPCFE_ST_FRAME: begin
        // Start code is the one on the last frame clock
        if (!in_frame) begin
          if (is_start(code_r)) begin
            state_nxt = `LPCFE_ST_CYCLE;
          end else begin
            state_nxt = `LPCFE_ST_IDLE;
          end
        end
      end
      `LPCFE_ST_CYCLE: begin
        if (in_frame) begin
          state_nxt = `LPCFE_ST_FRAME;
        end else if (driving && resp_last) begin
          state_nxt = `LPCFE_ST_TAR;
        end else if (cyc_end) begin
          state_nxt = `LPCFE_ST_IDLE;
        end
      end
      `LPCFE_ST_TAR: begin
        if (in_frame) begin
          state_nxt = `LPCFE_ST_FRAME;
        end else begin
          state_nxt = `LPCFE_ST_IDLE;
        end
      end
      default: begin
        state_nxt = `LPCFE_ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= `LPCFE_ST_IDLE;
      code_r <= `LPCFE_NIB_RST;
    end else if (!lpc_run) begin
      state_r <= `LPCFE_ST_IDLE;
      code_r <= `LPCFE_NIB_RST;
    end else begin
      state_r <= state_nxt;
      if (in_frame) begin
        code_r <= lad_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request side outputs

  wire start_now = (state_r == `LPCFE_ST_FRAME) & ~in_frame & is_start(code_r);
  wire abort_now = ((state_r == `LPCFE_ST_CYCLE) | (state_r == `LPCFE_ST_TAR)) & in_frame;
  // First nibble rides on the clock that ends the frame, so it must be
  // taken there or the first nibble would be lost.
  wire take_nib = start_now | ((state_r == `LPCFE_ST_CYCLE) & ~in_frame & ~resp_valid);

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cyc_start <= 1'b0;
      cyc_type <= `LPCFE_NIB_RST;
      cyc_active <= 1'b0;
      cyc_abort <= 1'b0;
      nib_valid <= 1'b0;
      nib_data <= `LPCFE_NIB_RST;
      nib_idx <= `LPCFE_IDX_RST;
    end else if (!lpc_run) begin
      cyc_start <= 1'b0;
      cyc_type <= `LPCFE_NIB_RST;
      cyc_active <= 1'b0;
      cyc_abort <= 1'b0;
      nib_valid <= 1'b0;
      nib_data <= `LPCFE_NIB_RST;
      nib_idx <= `LPCFE_IDX_RST;
    end else begin
      cyc_start <= start_now;
      cyc_abort <= abort_now;
      cyc_active <= (state_nxt == `LPCFE_ST_CYCLE) | (state_nxt == `LPCFE_ST_TAR);
      nib_valid <= take_nib;
      if (start_now) begin
        cyc_type <= code_r;
        nib_idx <= `LPCFE_IDX_FIRST;
      end else if (take_nib && (nib_idx != {IDX_W{1'b1}})) begin
        // Index saturates rather than wraps on overlong cycles
        nib_idx <= nib_idx + 1'b1;
      end
      if (take_nib) begin
        nib_data <= lad_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive; enable is active low

  // A frame always wins over a pending response, so an abort releases
  // the lines on the very next edge.
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lad_o <= `LPCFE_NIB_RST;
      lad_oe_n <= 1'b1;
    end else if (!lpc_run) begin
      lad_o <= `LPCFE_NIB_RST;
      lad_oe_n <= 1'b1;
    end else if (resp_ready && resp_valid) begin
      lad_o <= resp_data;
      lad_oe_n <= 1'b0;
    end else if ((state_r == `LPCFE_ST_TAR) && !in_frame) begin
      lad_o <= `LPCFE_TAR_NIB;
      lad_oe_n <= 1'b0;
    end else begin
      lad_o <= `LPCFE_NIB_RST;
      lad_oe_n <= 1'b1;
    end
  end

endmodule

`default_nettype wire

/* lpcfe_map.vh */
`ifndef LPCFE_MAP_VH
`define LPCFE_MAP_VH

// Start field codes seen on the last frame nibble
`define LPCFE_START_MEM 4'h0
`define LPCFE_START_FW_RD 4'hD
`define LPCFE_START_FW_WR 4'hE
`define LPCFE_CODE_ABORT 4'hF

// Level the device drives during its turnaround nibble
`define LPCFE_TAR_NIB 4'hF

// Strap capture waits for the synchroniser to fill
`define LPCFE_STRAP_WAIT 2'h2
`define LPCFE_STRAP_CNT_W 2

// Cycle front-end states
`define LPCFE_ST_W 2
`define LPCFE_ST_IDLE 2'h0
`define LPCFE_ST_FRAME 2'h1
`define LPCFE_ST_CYCLE 2'h2
`define LPCFE_ST_TAR 2'h3

// Reset values
`define LPCFE_NIB_RST 4'h0
`define LPCFE_IDX_RST 5'h00
`define LPCFE_IDX_FIRST 5'h01

`endif

/* lpcfe_sync.v */
`timescale 1ns/1ns
`default_nettype none

module lpcfe_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  // Clock and reset
  input wire mclk,
  input wire nrst,
  // Data
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // First stage feeds only the second stage
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

`default_nettype wire

/* lpcfe_top_sva.sv */
`include "lpcfe_map.vh"
`timescale 1ns/1ns
`default_nettype none
module lpcfe_top_sva (
  // Clock and resets
  input wire logic mclk,
  input wire logic nrst,
  input wire logic init_n,
  // Mode
  input wire logic parallel_programming_mode,
  input wire logic lpc_mode,
  // Bus
  input wire logic lframe_n,
  input wire logic [3:0] lad_i,
  input wire logic [3:0] lad_o,
  input wire logic lad_oe_n,
  // Core side
  input wire logic cyc_start,
  input wire logic cyc_active,
  input wire logic cyc_abort,
  input wire logic resp_valid,
  input wire logic [3:0] resp_data,
  input wire logic resp_last,
  input wire logic resp_ready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_frame;
    init_n && lpc_mode && !cyc_active && !lframe_n && lad_i == `LPCFE_START_MEM ##1 lframe_n;
  endsequence
  sequence s_tar;
    !lad_oe_n && lad_o == `LPCFE_TAR_NIB ##1 lad_oe_n;
  endsequence
  property p_start; s_frame |=> cyc_start; endproperty
  a_start: assert property (p_start) else $error("no start after frame");
  property p_abort; init_n && lpc_mode && cyc_active && !lframe_n |=> cyc_abort; endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_resp; resp_valid && resp_ready |=> !lad_oe_n && lad_o == $past(resp_data); endproperty
  a_resp: assert property (p_resp) else $error("response not driven");
  property p_tar; resp_valid && resp_ready && resp_last ##1 lframe_n |=> s_tar; endproperty
  a_tar: assert property (p_tar) else $error("bad turnaround");
  property p_excl; !(parallel_programming_mode && lpc_mode); endproperty
  a_excl: assert property (p_excl) else $error("both modes on");
  property p_pp_quiet; parallel_programming_mode |-> lad_oe_n && !cyc_start && !cyc_active; endproperty
  a_pp_quiet: assert property (p_pp_quiet) else $error("bus active in parallel mode");
  property p_held; $fell(lpc_mode) |-> !$past(init_n, 2) || !$past(init_n, 3) || !$past(init_n, 4); endproperty
  a_held: assert property (p_held) else $error("mode lost without reset");
  property p_init; !init_n [*5] |-> lad_oe_n && !lpc_mode && !cyc_active; endproperty
  a_init: assert property (p_init) else $error("second reset ignored");
endmodule
bind lpcfe_top lpcfe_top_sva i_sva (.mclk(mclk), .nrst(nrst), .init_n(init_n),
  .parallel_programming_mode(parallel_programming_mode), .lpc_mode(lpc_mode), .lframe_n(lframe_n),
  .lad_i(lad_i), .lad_o(lad_o), .lad_oe_n(lad_oe_n), .cyc_start(cyc_start), .cyc_active(cyc_active),
  .cyc_abort(cyc_abort), .resp_valid(resp_valid), .resp_data(resp_data), .resp_last(resp_last),
  .resp_ready(resp_ready));
`default_nettype wire

/* lpcfe_host.sv */
`timescale 1ns/1ns
`default_nettype none
module lpcfe_host (
  // Clock
  input wire logic mclk,
  // Bus
  output logic lframe_n,
  output logic [3:0] lad
);
  initial begin
    lframe_n = 1'b1;
    lad = 4'hA;
  end
  task automatic frame(input logic [3:0] code, input logic [3:0] nib);
    @(posedge mclk);
    lframe_n <= 1'b0;
    lad <= code;
    @(posedge mclk);
    lframe_n <= 1'b1;
    lad <= nib;
    // Inverted after use so stale data is never mistaken for fresh
    @(posedge mclk);
    lad <= ~nib;
  endtask
endmodule
`default_nettype wire

/* test_lpcfe_top.sv */
`timescale 1ns/1ns
`default_nettype none
module test_lpcfe_top;
  logic mclk, nrst, init_n, mode_pin, cyc_end, resp_valid, resp_last, lframe_n;
  int ab_cnt = 0;
  logic [3:0] lad_i, lad_o, cyc_type, nib_data, resp_data;
  logic [4:0] nib_idx;
  logic ppm, lpm, lad_oe_n, cyc_start, cyc_active, cyc_abort, nib_valid, resp_ready;
  int n_errors = 0;
  int check_count = 0;
  lpcfe_top i_dut (.mclk(mclk), .nrst(nrst), .init_n(init_n), .mode_pin(mode_pin),
    .parallel_programming_mode(ppm), .lpc_mode(lpm), .lframe_n(lframe_n), .lad_i(lad_i), .lad_o(lad_o),
    .lad_oe_n(lad_oe_n), .cyc_start(cyc_start), .cyc_type(cyc_type), .cyc_active(cyc_active),
    .cyc_abort(cyc_abort), .nib_valid(nib_valid), .nib_data(nib_data), .nib_idx(nib_idx),
    .cyc_end(cyc_end), .resp_valid(resp_valid), .resp_data(resp_data), .resp_last(resp_last),
    .resp_ready(resp_ready));
  lpcfe_host i_host (.mclk(mclk), .lframe_n(lframe_n), .lad(lad_i));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) if (cyc_abort === 1'b1) ab_cnt <= ab_cnt + 1;
  task chk(input string nm, input logic [4:0] e, input logic [4:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task conclude;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task end_cycle;
    @(posedge mclk) cyc_end <= 1'b1;
    @(posedge mclk) cyc_end <= 1'b0;
    tick(1);
    chk("active", 5'h0, cyc_active);
  endtask
  task t_codes;
    logic [3:0] cs [3];
    cs = '{4'h0, 4'hD, 4'hE};
    foreach (cs[i]) begin
      i_host.frame(cs[i], 4'(i + 1));
      #1;
      chk("start", 5'h1, cyc_start);
      chk("type", cs[i], cyc_type);
      chk("nib", 4'(i + 1), nib_data);
      chk("idx", 5'h1, nib_idx);
      chk("nib valid", 5'h1, nib_valid);
      end_cycle();
    end
    i_host.frame(4'hF, 4'h1);
    #1;
    chk("bad start", 5'h0, cyc_start);
  endtask
  task t_abort;
    int ab0;
    i_host.frame(4'h0, 4'h1);
    tick(2);
    ab0 = ab_cnt;
    i_host.frame(4'hD, 4'h2);
    #1;
    chk("abort", 5'h1, 5'(ab_cnt - ab0));
    chk("restart", 5'h1, cyc_start);
    chk("type", 5'hD, cyc_type);
    end_cycle();
  endtask
  task t_resp;
    i_host.frame(4'hE, 4'h3);
    tick(1);
    chk("ready", 5'h1, resp_ready);
    @(posedge mclk) {resp_valid, resp_last, resp_data} <= {2'h3, 4'h5};
    @(posedge mclk) {resp_valid, resp_last} <= 2'h0;
    #1 chk("lad", 5'h5, lad_o);
    chk("oe", 5'h0, lad_oe_n);
    tick(1);
    chk("tar", 5'hF, lad_o);
    chk("tar oe", 5'h0, lad_oe_n);
    tick(1);
    chk("oe off", 5'h1, lad_oe_n);
  endtask
  task t_mode;
    @(posedge mclk) mode_pin <= 1'b1;
    tick(4);
    chk("lpc held", 5'h1, lpm);
    @(posedge mclk) init_n <= 1'b0;
    tick(6);
    chk("lpc init", 5'h0, lpm);
    @(posedge mclk) init_n <= 1'b1;
    tick(10);
    chk("pp", 5'h1, ppm);
    chk("lpc", 5'h0, lpm);
    i_host.frame(4'h0, 4'h1);
    #1;
    chk("pp start", 5'h0, cyc_start);
    @(posedge mclk) nrst <= 1'b0;
    #1 chk("pp rst", 5'h0, ppm);
    @(posedge mclk) mode_pin <= 1'b0;
    tick(3);
    @(posedge mclk) nrst <= 1'b1;
    tick(10);
    chk("lpc", 5'h1, lpm);
  endtask
  initial begin
    {nrst, init_n, mode_pin, cyc_end, resp_valid, resp_last} = 6'h10;
    resp_data = 4'h0;
    tick(4);
    @(posedge mclk) nrst <= 1'b1;
    tick(10);
    chk("lpc", 5'h1, lpm);
    chk("pp", 5'h0, ppm);
    t_codes();
    t_abort();
    t_resp();
    t_mode();
    conclude();
  end
  initial begin
    #100000;
    n_errors++;
    conclude();
  end
endmodule
`default_nettype wire
